// file: inc/smc_defs.svh
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// register offsets (byte addresses on the local register port)
`define SMC_ADDR_W        8
`define SMC_OFS_MODE0     8'h00
`define SMC_OFS_MODE1     8'h04
`define SMC_OFS_CTRL      8'h08
`define SMC_OFS_STAT      8'h0c

// mode register 0 fields
`define SMC_M0_NINTH      7
`define SMC_M0_CLEAR_TO_SEND_ENABLE       6
`define SMC_M0_RXE        5
`define SMC_M0_WU         4
`define SMC_M0_SM_HI      3
`define SMC_M0_SM_LO      2
`define SMC_M0_SC_HI      1
`define SMC_M0_SC_LO      0

// mode register 1 fields
`define SMC_M1_DPX_HI     6
`define SMC_M1_DPX_LO     5
`define SMC_M1_TXE        4
`define SMC_M1_INT_HI     3
`define SMC_M1_INT_LO     1

// control register fields
`define SMC_CT_CLKDIR     0
`define SMC_CT_DBUF       1
`define SMC_CT_FIFO       2

// status register fields
`define SMC_ST_CTS        0
`define SMC_ST_SCLK       1
`define SMC_ST_GAP        2
`define SMC_ST_NINTH      3

// reset values and widths
`define SMC_RST_MODE0     8'h00
`define SMC_RST_MODE1     8'h00
`define SMC_RST_CTRL      8'h00
`define SMC_REG_W         8
`define SMC_GAP_W         7

`endif

// file: inc/smc_pkg.sv
package smc_pkg;

  typedef enum logic [1:0] {
    SMC_MODE_IO    = 2'b00,
    SMC_MODE_UART7 = 2'b01,
    SMC_MODE_UART8 = 2'b10,
    SMC_MODE_UART9 = 2'b11
  } smc_mode_t;

  typedef enum logic [1:0] {
    SMC_CLK_TIMER  = 2'b00,
    SMC_CLK_BAUD   = 2'b01,
    SMC_CLK_SYS    = 2'b10,
    SMC_CLK_EXT    = 2'b11
  } smc_clk_src_t;

  typedef enum logic [1:0] {
    SMC_DPX_OFF    = 2'b00,
    SMC_DPX_RX     = 2'b01,
    SMC_DPX_TX     = 2'b10,
    SMC_DPX_FULL   = 2'b11
  } smc_duplex_t;

  typedef enum logic [0:0] {
    SMC_GAP_IDLE   = 1'b0,
    SMC_GAP_WAIT   = 1'b1
  } smc_gap_state_t;

  // one register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } smc_regreq_t;

  // frame end report from the receive shifter
  typedef struct packed {
    logic done;
    logic ninth;
  } smc_rx_event_t;

endpackage : smc_pkg

// file: verilog/smc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// three-stage pin synchroniser; output moves only when stages two and three agree
module smc_pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic clk_sys,  // system clock
  input  wire logic arst_n,   // async reset, active low
  input  wire logic pinIn,    // raw pin level
  output logic      level     // filtered level
);

  logic stage1;
  logic stage2;
  logic stage3;

  // stage1 feeds stage2 only, so metastability never reaches the filter
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= RESET_LEVEL;
      stage2 <= RESET_LEVEL;
      stage3 <= RESET_LEVEL;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a one-cycle disagreement is ignored as a glitch
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      level <= RESET_LEVEL;
    end else if (stage2 == stage3) begin
      level <= stage3;
    end
  end

endmodule : smc_pin_sync

`default_nettype wire

// file: verilog/smc_mode_control.sv
// Behaviour
// - nine-bit mode sends ninth bit from register
// - handshake enable bit gates transmit by pin
// - handshake ignored in clocked interface mode
// - wake-up passes only frames with ninth bit
// - wake-up ignored outside nine-bit mode
// - mode field selects interface or uart width
// - uart clock source from source field
// - interface mode clock from direction bit
// - duplex field selects off, rx, tx, full
// - duplex sets fifo layout; uart only fifo
// - transmit enable gates every mode
// - interval field inserts 0..64 clock gap
// - interval only in interface clock-output mode
// - interval only with double buffer or fifo
// - direction bit drives or accepts serial clock
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.svh"

module smc_mode_control (
  input  wire logic                  clk_sys,        // system clock, 100 MHz
  input  wire logic                  arst_n,         // async reset, active low
  input  wire smc_pkg::smc_regreq_t  regReq,         // register port request
  output logic [31:0]                regRdata,       // read data, cycle after read
  input  wire logic                  ctsPin_n,       // clear-to-send pin, low = clear
  input  wire logic                  sclkPinIn,      // serial clock pin input level
  output logic                       sclkPinOut,     // serial clock pin output level
  output logic                       sclkPinOe_n,    // serial clock pin enable, low = drive
  input  wire logic                  timerTick,      // timer output pulse
  input  wire logic                  baudTick,       // baud generator pulse
  input  wire logic                  baudLevel,      // baud generator clock level
  input  wire smc_pkg::smc_rx_event_t rxEvent,       // frame end from receiver
  input  wire logic                  txCharDone,     // transmitter finished a character
  output logic                       xferClkTick,    // selected transfer clock pulse
  output smc_pkg::smc_mode_t         xferMode,       // active transfer mode
  output logic                       txNinthBit,     // ninth bit to transmit
  output logic                       txGo,           // transmitter may start
  output logic                       rxGo,           // receiver may run
  output logic                       rxIrq,          // receive interrupt pulse
  output logic [1:0]                 fifoLayout      // fifo arrangement, 00 when off
);

  logic [7:0]            mode0;
  logic [7:0]            mode1;
  logic [7:0]            ctrl;
  logic                  ctsLevel;
  logic                  sclkLevel;
  logic                  sclkPrev;
  logic                  lastNinth;
  smc_pkg::smc_gap_state_t gapState;
  logic [6:0]            gapCount;

  smc_pkg::smc_mode_t    modeSel;
  smc_pkg::smc_clk_src_t clkSrc;
  smc_pkg::smc_duplex_t  duplex;
  logic                  isIo;
  logic                  clkDirIn;
  logic                  txeBit;
  logic                  rxeBit;
  logic                  gapEnabled;
  logic                  sclkRise;
  logic                  ctsOk;
  logic                  irqPass;

  // map an interval code to a count of serial clock cycles
  function automatic logic [6:0] gap_cycles(input logic [2:0] code);
    logic [6:0] cnt;
    cnt = 7'h00;
    if (code != 3'h0) begin
      cnt = 7'(7'h01 << (code - 3'h1));
    end
    return cnt;
  endfunction : gap_cycles

  // decode of register fields; modes are shared by many processes
  assign modeSel  = smc_pkg::smc_mode_t'(mode0[`SMC_M0_SM_HI:`SMC_M0_SM_LO]);
  assign clkSrc   = smc_pkg::smc_clk_src_t'(mode0[`SMC_M0_SC_HI:`SMC_M0_SC_LO]);
  assign duplex   = smc_pkg::smc_duplex_t'(mode1[`SMC_M1_DPX_HI:`SMC_M1_DPX_LO]);
  assign isIo     = (modeSel == smc_pkg::SMC_MODE_IO);
  assign clkDirIn = ctrl[`SMC_CT_CLKDIR];
  assign txeBit   = mode1[`SMC_M1_TXE];
  assign rxeBit   = mode0[`SMC_M0_RXE];
  assign sclkRise = sclkLevel && !sclkPrev;

  // interval only in interface mode with own clock and back-to-back buffering
  assign gapEnabled = isIo && !clkDirIn
                      && (ctrl[`SMC_CT_DBUF] || ctrl[`SMC_CT_FIFO]);

  // handshake applies in uart modes only
  assign ctsOk = isIo || !mode0[`SMC_M0_CLEAR_TO_SEND_ENABLE] || !ctsLevel;

  // wake-up filter only meaningful in nine-bit mode
  assign irqPass = !(modeSel == smc_pkg::SMC_MODE_UART9 && mode0[`SMC_M0_WU])
                   || rxEvent.ninth;

  // pins from outside the clock domain
  smc_pin_sync #(
    .RESET_LEVEL (1'b1)
  ) u_cts_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .pinIn   (ctsPin_n),
    .level   (ctsLevel)
  );

  // serial clock idles high, so the filter and edge detector reset high: no false edge
  smc_pin_sync #(
    .RESET_LEVEL (1'b1)
  ) u_sclk_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .pinIn   (sclkPinIn),
    .level   (sclkLevel)
  );

  // register writes; only the low byte is stored, only bits 2:0 for the control register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode0 <= `SMC_RST_MODE0;
      mode1 <= `SMC_RST_MODE1;
      ctrl  <= `SMC_RST_CTRL;
    end else if (regReq.wr) begin
      case (regReq.addr)
        `SMC_OFS_MODE0: begin
          mode0 <= regReq.wdata[7:0];
        end
        `SMC_OFS_MODE1: begin
          mode1 <= regReq.wdata[7:0];
        end
        `SMC_OFS_CTRL: begin
          ctrl  <= {5'h00, regReq.wdata[2:0]};
        end
        default: begin
        end
      endcase
    end
  end

  // register reads answer one cycle later; unmapped offsets read zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 32'h0000_0000;
    end else if (regReq.rd) begin
      case (regReq.addr)
        `SMC_OFS_MODE0: regRdata <= {24'h00_0000, mode0};
        `SMC_OFS_MODE1: regRdata <= {24'h00_0000, mode1};
        `SMC_OFS_CTRL:  regRdata <= {24'h00_0000, ctrl};
        `SMC_OFS_STAT:  regRdata <= {28'h000_0000, lastNinth, (gapState == smc_pkg::SMC_GAP_WAIT),
                                     sclkLevel, ctsLevel};
        default:        regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  // previous serial clock level for edge detection
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclkPrev <= 1'b1;
    end else begin
      sclkPrev <= sclkLevel;
    end
  end

  // transfer clock selection
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      xferClkTick <= 1'b0;
    end else if (isIo) begin
      xferClkTick <= clkDirIn ? sclkRise : baudTick;
    end else begin
      case (clkSrc)
        smc_pkg::SMC_CLK_TIMER: xferClkTick <= timerTick;
        smc_pkg::SMC_CLK_BAUD:  xferClkTick <= baudTick;
        smc_pkg::SMC_CLK_SYS:   xferClkTick <= 1'b1;
        smc_pkg::SMC_CLK_EXT:   xferClkTick <= sclkRise;
        default:                xferClkTick <= 1'b0;
      endcase
    end
  end

  // serial clock pin: driven only in interface mode with direction bit low
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclkPinOut  <= 1'b1;
      sclkPinOe_n <= 1'b1;
    end else begin
      sclkPinOut  <= isIo ? baudLevel : 1'b1;
      sclkPinOe_n <= !(isIo && !clkDirIn);
    end
  end

  // gap counter between back-to-back transmissions, counted in own clock cycles
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gapState <= smc_pkg::SMC_GAP_IDLE;
      gapCount <= 7'h00;
    end else begin
      case (gapState)
        smc_pkg::SMC_GAP_IDLE: begin
          if (txCharDone && gapEnabled
              && (gap_cycles(mode1[`SMC_M1_INT_HI:`SMC_M1_INT_LO]) != 7'h00)) begin
            gapState <= smc_pkg::SMC_GAP_WAIT;
            gapCount <= gap_cycles(mode1[`SMC_M1_INT_HI:`SMC_M1_INT_LO]);
          end
        end
        smc_pkg::SMC_GAP_WAIT: begin
          // leaving the clocking mode mid-gap abandons the wait
          if (!gapEnabled) begin
            gapState <= smc_pkg::SMC_GAP_IDLE;
            gapCount <= 7'h00;
          end else if (baudTick) begin
            gapCount <= gapCount - 7'h01;
            if (gapCount == 7'h01) begin
              gapState <= smc_pkg::SMC_GAP_IDLE;
            end
          end
        end
        default: begin
          gapState <= smc_pkg::SMC_GAP_IDLE;
          gapCount <= 7'h00;
        end
      endcase
    end
  end

  // transmit gate: enable, direction, handshake and gap together
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      txGo <= 1'b0;
    end else begin
      txGo <= txeBit
              && (!isIo || duplex[1])
              && ctsOk
              && (gapState == smc_pkg::SMC_GAP_IDLE);
    end
  end

  // receive gate; in uart modes the duplex field does not steer direction
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rxGo <= 1'b0;
    end else begin
      rxGo <= rxeBit && (!isIo || duplex[0]);
    end
  end

  // receive interrupt with wake-up filtering; last ninth bit kept for status
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rxIrq     <= 1'b0;
      lastNinth <= 1'b0;
    end else begin
      rxIrq <= rxEvent.done && rxeBit && irqPass;
      if (rxEvent.done) begin
        lastNinth <= rxEvent.ninth;
      end
    end
  end

  // mode, ninth bit and fifo layout outputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      xferMode   <= smc_pkg::SMC_MODE_IO;
      txNinthBit <= 1'b0;
      fifoLayout <= 2'b00;
    end else begin
      xferMode   <= modeSel;
      txNinthBit <= (modeSel == smc_pkg::SMC_MODE_UART9) && mode0[`SMC_M0_NINTH];
      fifoLayout <= ctrl[`SMC_CT_FIFO] ? duplex : 2'b00;
    end
  end

  a_ninth_bit_path: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (regReq.wr && regReq.addr == `SMC_OFS_MODE0 && regReq.wdata[3:2] == 2'b11) ##1 !regReq.wr
    |=> txNinthBit == $past(regReq.wdata[7], 2))
    else $error("ninth bit does not follow mode register");

  a_cts_blocks_tx: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (!isIo && mode0[`SMC_M0_CLEAR_TO_SEND_ENABLE] && ctsLevel) |=> !txGo)
    else $error("transmit allowed while not clear to send");

  a_cts_io_ignored: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (isIo && txeBit && duplex[1] && gapState == smc_pkg::SMC_GAP_IDLE) |=> txGo)
    else $error("handshake wrongly blocks interface mode");

  a_wakeup_filter: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (rxEvent.done && modeSel == smc_pkg::SMC_MODE_UART9 && mode0[`SMC_M0_WU] && !rxEvent.ninth)
    |=> !rxIrq)
    else $error("wake-up filter passed a frame without ninth bit");

  a_wakeup_other: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (rxEvent.done && rxeBit && modeSel != smc_pkg::SMC_MODE_UART9) |=> rxIrq)
    else $error("receive interrupt lost outside nine-bit mode");

  a_tx_enable_gate: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !txeBit |=> !txGo)
    else $error("transmit allowed with transmit disabled");

  a_gap_load_count: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(gapState == smc_pkg::SMC_GAP_WAIT)
    |-> (gapCount == gap_cycles($past(mode1[`SMC_M1_INT_HI:`SMC_M1_INT_LO]))) ##1 !txGo)
    else $error("gap count loaded wrongly");

  a_gap_only_io: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (gapState == smc_pkg::SMC_GAP_IDLE && !gapEnabled) |=> gapState == smc_pkg::SMC_GAP_IDLE)
    else $error("gap inserted outside interface clock-output mode");

  a_sclk_drive: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (isIo && !clkDirIn) ##1 (isIo && !clkDirIn) |-> !sclkPinOe_n)
    else $error("serial clock not driven in clock-output mode");

  a_upper_zero: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    regReq.rd |=> regRdata[31:8] == 24'h00_0000)
    else $error("upper register bits not zero");

endmodule : smc_mode_control

`default_nettype wire

// file: testbench/smc_serial_peer.sv
`timescale 1ns/1ps
`default_nettype none

// far-side serial peer: owns the handshake line and can supply the serial clock
module smc_serial_peer (
  input  wire logic clk_sys,     // system clock
  input  wire logic ctsClear,    // bench command, peer ready to accept data
  input  wire logic extClkOn,    // bench command, peer supplies the clock
  input  wire logic sclkPinOut,  // device clock drive value
  input  wire logic sclkPinOe_n, // device clock enable, low = drive
  output logic      ctsPin_n,    // handshake line, low = clear
  output logic      sclkWire     // resolved clock pin level
);
  logic [1:0] divCnt   = 2'b00;
  logic       peerClk  = 1'b0;
  logic       floatLvl = 1'b0;

  // peer clock of eight system cycles, slow enough to pass the pin filter; still when off
  always @(posedge clk_sys) begin
    if (!extClkOn) begin
      divCnt  <= 2'b00;
      peerClk <= 1'b0;
    end else begin
      divCnt <= divCnt + 2'b01;
      if (divCnt == 2'b11) peerClk <= ~peerClk;
    end
  end

  // a released pin has no keeper: it floats to the inverse of the last driven level
  always @(posedge clk_sys) begin
    if (!sclkPinOe_n) floatLvl <= ~sclkPinOut;
  end

  // handshake is active low
  assign ctsPin_n = ~ctsClear;
  // device drive wins, then the peer clock, else the held free level, the inverse of the last driven level
  assign sclkWire = !sclkPinOe_n ? sclkPinOut : (extClkOn ? peerClk : floatLvl);
endmodule : smc_serial_peer

`default_nettype wire

// file: testbench/smc_mode_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.svh"

module smc_mode_control_bench;
  logic                   clk_sys = 1'b0;
  logic                   arst_n = 1'b0;
  smc_pkg::smc_regreq_t   regReq = '0;
  smc_pkg::smc_rx_event_t rxEvent = '0;
  smc_pkg::smc_mode_t     xferMode;
  logic [31:0]            regRdata;
  logic [1:0]             fifoLayout;
  logic sclkPinOut, sclkPinOe_n, ctsPin_n, sclkWire, xferClkTick, txNinthBit, txGo, rxGo, rxIrq;
  logic timerTick = 0, baudTick = 0, baudLevel = 0, txCharDone = 0;
  logic ctsClear = 0, extClkOn = 0, probe = 0, rdD = 0, gapOn = 0;
  logic [7:0]             m0 = 0, m1 = 0, ct = 0;
  logic [31:0]            rdQ[$];
  logic [9:0]             gateQ[$];
  logic                   irqQ[$];
  int                     n_mismatch = 0, compares = 0, cyc = 0;

  always #5 clk_sys = ~clk_sys;

  smc_mode_control dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .regReq(regReq), .regRdata(regRdata),
    .ctsPin_n(ctsPin_n), .sclkPinIn(sclkWire), .sclkPinOut(sclkPinOut),
    .sclkPinOe_n(sclkPinOe_n), .timerTick(timerTick), .baudTick(baudTick),
    .baudLevel(baudLevel), .rxEvent(rxEvent), .txCharDone(txCharDone),
    .xferClkTick(xferClkTick), .xferMode(xferMode), .txNinthBit(txNinthBit),
    .txGo(txGo), .rxGo(rxGo), .rxIrq(rxIrq), .fifoLayout(fifoLayout));

  smc_serial_peer peer (
    .clk_sys(clk_sys), .ctsClear(ctsClear), .extClkOn(extClkOn),
    .sclkPinOut(sclkPinOut), .sclkPinOe_n(sclkPinOe_n), .ctsPin_n(ctsPin_n),
    .sclkWire(sclkWire));

  task automatic print_verdict();
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic fail(input string msg);
    n_mismatch++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : fail

  task automatic cmpRead(input logic [31:0] exp);
    compares++;
    if (regRdata !== exp) fail($sformatf("read data %h, expected %h", regRdata, exp));
  endtask : cmpRead

  task automatic cmpGate(input logic [9:0] exp);
    compares++;
    if ({txGo, rxGo, xferMode, txNinthBit, fifoLayout, sclkPinOe_n} !== exp[7:0]) fail("gate outputs");
    if (exp[9] && xferClkTick !== exp[8]) fail("transfer clock tick");
    if (sclkPinOut !== ((m0[3:2] == 2'b00) ? ~baudLevel : 1'b1)) fail("clock drive level");
  endtask : cmpGate

  task automatic cmpTicks(input int got, input int exp);
    compares++;
    if (got != exp) fail($sformatf("transfer clock ticks %0d, expected %0d", got, exp));
  endtask : cmpTicks

  task automatic cmpIrq(input logic exp);
    compares++;
    if (exp !== 1'b1) fail("receive interrupt mismatch");
  endtask : cmpIrq

  // expected gate levels from the shadow registers
  function automatic logic [7:0] expGate();
    logic io;
    logic ctsOk;
    io    = (m0[3:2] == 2'b00);
    ctsOk = io || !m0[6] || ctsClear;
    return {m1[4] && ctsOk && (io ? m1[6] : 1'b1) && !gapOn, m0[5] && (io ? m1[5] : 1'b1),
            m0[3:2], (m0[3:2] == 2'b11) && m0[7], ct[2] ? m1[6:5] : 2'b00, !(io && !ct[0])};
  endfunction : expGate

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    regReq.wr <= 1'b0;
  endtask : wr

  task automatic regRead(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    rdQ.push_back(e);
    @(posedge clk_sys);
    regReq.rd <= 1'b0;
  endtask : regRead

  // enables go last and drop first, never while a character is in flight
  task automatic cfg(input logic [7:0] a0, input logic [7:0] a1, input logic [7:0] c);
    wr(`SMC_OFS_MODE0, {24'h0, a0 & 8'hdf});
    wr(`SMC_OFS_MODE1, {24'h0, a1 & 8'hef});
    wr(`SMC_OFS_CTRL, {24'h0, c});
    wr(`SMC_OFS_MODE0, {24'h0, a0});
    wr(`SMC_OFS_MODE1, {24'h0, a1});
    m0 = a0;
    m1 = a1;
    ct = c;
    idle(3);
  endtask : cfg

  task automatic check(input logic care, input logic tick);
    @(posedge clk_sys);
    probe <= 1'b1;
    gateQ.push_back({care, tick, expGate()});
    @(posedge clk_sys);
    probe <= 1'b0;
  endtask : check

  task automatic tick(input logic t, input logic b, input logic care, input logic e);
    @(posedge clk_sys);
    timerTick <= t;
    baudTick  <= b;
    @(posedge clk_sys);
    timerTick <= 1'b0;
    baudTick  <= 1'b0;
    probe     <= 1'b1;
    gateQ.push_back({care, e, expGate()});
    @(posedge clk_sys);
    probe <= 1'b0;
  endtask : tick

  task automatic gapRun(input logic [2:0] code, input logic [2:0] c);
    int n;
    n = (code == 3'd0 || c[0] || c[2:1] == 2'b00) ? 0 : (1 << (code - 1));
    extClkOn = c[0];
    cfg(8'h00, {4'b0101, code, 1'b0}, {5'h0, c});
    @(posedge clk_sys);
    txCharDone <= 1'b1;
    @(posedge clk_sys);
    txCharDone <= 1'b0;
    gapOn = (n != 0);
    idle(1);
    check(1'b0, 1'b0);
    for (int i = 0; i < n; i++) tick(1'b0, 1'b1, 1'b0, 1'b0);
    gapOn = 1'b0;
    check(1'b0, 1'b0);
  endtask : gapRun

  // watcher: each result that appears takes the oldest note of its kind
  always @(posedge clk_sys) begin
    cyc++;
    baudLevel <= ~baudLevel;
    if (rdD) cmpRead(rdQ.pop_front());
    rdD <= regReq.rd;
    if (probe) cmpGate(gateQ.pop_front());
    if (rxIrq === 1'b1) cmpIrq(irqQ.size() > 0);
    if (rxIrq === 1'b1 && irqQ.size() > 0) void'(irqQ.pop_front());
  end

  // hang guard, the whole sequence needs under two thousand cycles
  initial begin
    wait (cyc >= 20000);
    fail("timeout");
    print_verdict();
  end

  initial begin
    logic [31:0] v;
    int          seed;
    int          nTick;
    seed = $urandom(7176);
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    idle(2);
    regRead(`SMC_OFS_MODE0, 32'h0);
    regRead(`SMC_OFS_MODE1, 32'h0);
    check(1'b0, 1'b0);
    // readback keeps only the low byte; an unmapped word stays silent
    repeat (4) begin
      v = $urandom & 32'hffff_ffdf;
      wr(`SMC_OFS_MODE0, v);
      regRead(`SMC_OFS_MODE0, {24'h0, v[7:0]});
      v = $urandom & 32'hffff_ffee;
      wr(`SMC_OFS_MODE1, v);
      regRead(`SMC_OFS_MODE1, {24'h0, v[7:0]});
      wr(8'h10, v);
      regRead(8'h10, 32'h0);
    end
    for (int k = 0; k < 8; k++) begin
      cfg({k[0], 3'b001, k[2:1], 2'b01}, 8'h00, 8'h00);
      check(1'b0, 1'b0);
    end
    for (int k = 0; k < 4; k++) begin
      cfg({6'b000010, k[1:0]}, 8'h00, 8'h00);
      tick(1'b1, 1'b0, 1'b1, k == 0 || k == 2);
      tick(1'b0, 1'b1, 1'b1, k == 1 || k == 2);
    end
    // external source still selected: one tick per eight-cycle peer clock period
    extClkOn = 1'b1;
    idle(16);
    nTick = 0;
    repeat (32) begin
      @(posedge clk_sys);
      nTick += int'(xferClkTick === 1'b1);
    end
    extClkOn = 1'b0;
    cmpTicks(nTick, 4);
    for (int k = 0; k < 8; k++) begin
      ctsClear <= k[0];
      cfg({1'b0, k[1], 2'b00, k[2], 3'b001}, 8'h50, 8'h00);
      check(1'b0, 1'b0);
    end
    for (int k = 0; k < 16; k++) begin
      v = $urandom;
      cfg({2'b00, v[0], 1'b0, k[3], 3'b001}, {1'b0, k[1:0], v[1], 4'h0}, {5'h0, k[2], 2'b00});
      check(1'b0, 1'b0);
    end
    for (int k = 0; k < 16; k++) begin
      cfg({2'b00, k[3], k[1], 1'b1, k[2], 2'b01}, 8'h00, 8'h00);
      @(posedge clk_sys);
      rxEvent <= '{done: 1'b1, ninth: k[0]};
      if (k[3] && (!(k[2] && k[1]) || k[0])) irqQ.push_back(1'b1);
      @(posedge clk_sys);
      rxEvent.done <= 1'b0;
      idle(3);
      cmpIrq(irqQ.size() == 0);
    end
    for (int k = 0; k < 11; k++) begin
      gapRun((k < 8) ? k[2:0] : 3'd3, (k == 8) ? 3'd0 : (k == 9) ? 3'd4 : (k == 10) ? 3'd1 : 3'd2);
    end
    print_verdict();
  end
endmodule : smc_mode_control_bench

`default_nettype wire
